// *** verilog/ccm_top.sv ***
// Complex conjugate multiply datapath with parallel move and Avalon-MM register access
//
// The address map and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module ccm_top (
    input  wire logic                 CLK,
    input  wire logic                 SYS_RST,
    input  wire logic [5:0]           AVS_ADDRESS,
    input  wire logic                 AVS_READ,
    input  wire logic                 AVS_WRITE,
    input  wire logic [31:0]          AVS_WRITEDATA,
    output logic [31:0]               AVS_READDATA,
    output logic                      AVS_WAITREQUEST,
    input  ccm_pkg::ccm_insn_t        INSN,
    input  wire logic [31:0]          MEM_RDATA,
    output ccm_pkg::ccm_store_t       MEM_ST,
    output logic                      REAL_OVF,
    output logic                      IMAG_OVF
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [ccm_pkg::NUM_VREG-1:0][31:0] vreg;
        logic [1:0]                         cfg;
        logic                               ovf_re;
        logic                               ovf_im;
        logic                               rd_pend;
        logic [31:0]                        rdata;
        ccm_pkg::ccm_store_t                st;
    } ccm_state_t;

    ccm_state_t         state_q;
    ccm_state_t         state_d;
    ccm_pkg::ccm_prod_t prod;
    logic               is_plain;
    logic               is_store;
    logic               is_load;
    logic               is_mul;
    logic [3:0]         sel;
    logic [32:0]        sum_re;
    logic [32:0]        sum_im;
    logic               bus_hit_vreg;
    logic [3:0]         bus_idx;

    // ************************************************************
    // Decode
    // ************************************************************
    // Long forms need the tag nibble in the high word
    assign is_plain = INSN.valid && (INSN.lsw == ccm_pkg::OPC_PLAIN);
    assign is_store = INSN.valid && (INSN.lsw == ccm_pkg::OPC_STORE)
                      && (INSN.msw[ccm_pkg::MSW_TAG_LSB +: 4] == ccm_pkg::MSW_TAG);
    assign is_load  = INSN.valid && (INSN.lsw == ccm_pkg::OPC_LOAD)
                      && (INSN.msw[ccm_pkg::MSW_TAG_LSB +: 4] == ccm_pkg::MSW_TAG);
    assign is_mul   = is_plain || is_store || is_load;
    assign sel      = INSN.msw[ccm_pkg::MSW_SEL_LSB +: 4];

    // ************************************************************
    // Multiply stage and result arithmetic
    // ************************************************************
    ccm_mul_stage u_mul (
        .clk   (CLK),
        .rst   (SYS_RST),
        .start (is_mul),
        .pack  (state_q.cfg[ccm_pkg::CFG_PACK]),
        .op_x  (state_q.vreg[ccm_pkg::IDX_X]),
        .op_y  (state_q.vreg[ccm_pkg::IDX_Y]),
        .prod  (prod)
    );

    // One extra bit catches the lone overflow cases at full scale
    assign sum_re = ccm_pkg::sum33(prod.re_a, prod.re_b, 1'b0);
    assign sum_im = ccm_pkg::sum33(prod.im_a, prod.im_b, 1'b1);

    // Bus decode of the vector register window
    assign bus_idx      = AVS_ADDRESS[5:2];
    assign bus_hit_vreg = (AVS_ADDRESS[1:0] == 2'b00) && (AVS_ADDRESS >= ccm_pkg::OFF_VREG)
                          && (bus_idx < 4'(ccm_pkg::NUM_VREG));

    // ************************************************************
    // Next state
    // ************************************************************
    // Bus writes first; pipeline effects override in the same cycle
    always_comb begin
        state_d        = state_q;
        state_d.st.wr  = 1'b0;
        state_d.rd_pend = AVS_READ && !state_q.rd_pend;
        // Read data captured one cycle ahead of the answer
        if (AVS_READ && !state_q.rd_pend) begin
            if (bus_hit_vreg) begin
                state_d.rdata = state_q.vreg[bus_idx];
            end else if (AVS_ADDRESS == ccm_pkg::OFF_STATUS) begin
                state_d.rdata = {30'h0000_0000, state_q.ovf_im, state_q.ovf_re};
            end else if (AVS_ADDRESS == ccm_pkg::OFF_CONFIG) begin
                state_d.rdata = {30'h0000_0000, state_q.cfg};
            end else begin
                state_d.rdata = 32'h0000_0000;
            end
        end
        if (AVS_WRITE) begin
            if (bus_hit_vreg) begin
                state_d.vreg[bus_idx] = AVS_WRITEDATA;
            end else if (AVS_ADDRESS == ccm_pkg::OFF_CONFIG) begin
                state_d.cfg = AVS_WRITEDATA[1:0];
            end else if (AVS_ADDRESS == ccm_pkg::OFF_STATUS) begin
                // Write one to clear stands in for the dedicated clear instructions
                if (AVS_WRITEDATA[ccm_pkg::ST_OVF_RE]) begin
                    state_d.ovf_re = 1'b0;
                end
                if (AVS_WRITEDATA[ccm_pkg::ST_OVF_IM]) begin
                    state_d.ovf_im = 1'b0;
                end
            end
        end
        // Second stage lands one cycle after the products
        if (prod.valid) begin
            state_d.vreg[ccm_pkg::IDX_REAL] = ccm_pkg::fit32(sum_re, state_q.cfg[ccm_pkg::CFG_SAT]);
            state_d.vreg[ccm_pkg::IDX_IMAG] = ccm_pkg::fit32(sum_im, state_q.cfg[ccm_pkg::CFG_SAT]);
            // Sticky: only ever set here, and set beats a same-cycle clear
            if (ccm_pkg::ovf33(sum_re)) begin
                state_d.ovf_re = 1'b1;
            end
            if (ccm_pkg::ovf33(sum_im)) begin
                state_d.ovf_im = 1'b1;
            end
        end
        // Parallel store: selected register read in the issue cycle
        if (is_store) begin
            state_d.st.wr   = 1'b1;
            state_d.st.addr = INSN.msw[ccm_pkg::MSW_MEM_LSB +: ccm_pkg::MEM_AW];
            state_d.st.data = state_q.vreg[sel];
        end
        // Parallel load: visible to the very next instruction
        if (is_load && (sel < 4'(ccm_pkg::NUM_VREG))) begin
            state_d.vreg[sel] = MEM_RDATA;
        end
    end

    // State register
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            state_q         <= '0;
            state_q.vreg    <= {ccm_pkg::NUM_VREG{ccm_pkg::VREG_RST}};
            state_q.cfg     <= ccm_pkg::CONFIG_RST;
        end else begin
            state_q <= state_d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Writes answer at once, reads after one wait cycle
    assign AVS_WAITREQUEST = AVS_READ && !state_q.rd_pend;
    assign AVS_READDATA    = state_q.rdata;
    assign MEM_ST          = state_q.st;
    assign REAL_OVF        = state_q.ovf_re;
    assign IMAG_OVF        = state_q.ovf_im;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    // Reference value of the real result from the operands two cycles back
    function automatic logic [31:0] ref_re(input logic [31:0] x, input logic [31:0] y, input logic p);
        logic [32:0] s;
        s = p ? ccm_pkg::sum33(ccm_pkg::mul16(x[15:0], y[15:0]), ccm_pkg::mul16(x[31:16], y[31:16]), 1'b0)
              : ccm_pkg::sum33(ccm_pkg::mul16(x[31:16], y[31:16]), ccm_pkg::mul16(x[15:0], y[15:0]), 1'b0);
        ref_re = s[31:0];
    endfunction

    // Reference value of the imaginary result, built from the operands and the pack bit
    function automatic logic [31:0] ref_im(input logic [31:0] x, input logic [31:0] y, input logic p);
        logic [32:0] s;
        s = p ? ccm_pkg::sum33(ccm_pkg::mul16(x[15:0], y[31:16]), ccm_pkg::mul16(x[31:16], y[15:0]), 1'b1)
              : ccm_pkg::sum33(ccm_pkg::mul16(x[31:16], y[15:0]), ccm_pkg::mul16(x[15:0], y[31:16]), 1'b1);
        ref_im = s[31:0];
    endfunction

    a_plain_decode: assert property (is_plain |=> prod.valid)
        else $error("plain opcode did not start the multiply");
    a_real_formula: assert property (is_mul && !state_q.cfg[ccm_pkg::CFG_SAT]
        && !AVS_WRITE ##1 !AVS_WRITE
        |=> state_q.vreg[ccm_pkg::IDX_REAL] == ref_re($past(state_q.vreg[ccm_pkg::IDX_X], 2),
            $past(state_q.vreg[ccm_pkg::IDX_Y], 2), $past(state_q.cfg[ccm_pkg::CFG_PACK], 2)))
        else $error("real result wrong two cycles after issue");
    a_sat_clamp: assert property (prod.valid && state_q.cfg[ccm_pkg::CFG_SAT] && ccm_pkg::ovf33(sum_im)
        |=> state_q.vreg[ccm_pkg::IDX_IMAG] == ccm_pkg::SAT_POS || state_q.vreg[ccm_pkg::IDX_IMAG] == ccm_pkg::SAT_NEG)
        else $error("saturated imaginary result not clamped");
    // Only the real sum can leave 32 bits, when all four halves are full-scale negative
    a_sat_real: assert property (prod.valid && state_q.cfg[ccm_pkg::CFG_SAT] && ccm_pkg::ovf33(sum_re)
        |=> state_q.vreg[ccm_pkg::IDX_REAL] == ccm_pkg::SAT_POS || state_q.vreg[ccm_pkg::IDX_REAL] == ccm_pkg::SAT_NEG)
        else $error("saturated real result not clamped");
    a_wrap_value: assert property (is_mul && !state_q.cfg[ccm_pkg::CFG_SAT]
        && !AVS_WRITE ##1 !AVS_WRITE
        |=> state_q.vreg[ccm_pkg::IDX_IMAG] == ref_im($past(state_q.vreg[ccm_pkg::IDX_X], 2),
            $past(state_q.vreg[ccm_pkg::IDX_Y], 2), $past(state_q.cfg[ccm_pkg::CFG_PACK], 2)))
        else $error("imaginary result not the wrapped difference");
    a_real_flag: assert property (prod.valid && ccm_pkg::ovf33(sum_re) |=> REAL_OVF)
        else $error("real overflow flag not set");
    a_imag_flag: assert property (prod.valid && ccm_pkg::ovf33(sum_im) |=> IMAG_OVF)
        else $error("imaginary overflow flag not set");
    a_flag_sticky: assert property (REAL_OVF && !(AVS_WRITE && AVS_ADDRESS == ccm_pkg::OFF_STATUS) |=> REAL_OVF)
        else $error("real overflow flag dropped without a clear");
    a_store_word: assert property (is_store |=> MEM_ST.wr
        && MEM_ST.data == $past(state_q.vreg[sel]) && MEM_ST.addr == $past(INSN.msw[7:0]))
        else $error("parallel store did not write the selected word");
    a_store_single: assert property (MEM_ST.wr && !$past(is_store, 2) ##0 !is_store |=> !MEM_ST.wr)
        else $error("store strobe held too long");
    a_load_next: assert property (is_load && sel != 4'(ccm_pkg::IDX_REAL)
        && sel != 4'(ccm_pkg::IDX_IMAG) && sel < 4'(ccm_pkg::NUM_VREG)
        |=> state_q.vreg[$past(sel)] == $past(MEM_RDATA))
        else $error("parallel load not visible to the next instruction");

    c_plain_run: cover property (is_plain ##2 !REAL_OVF);
    c_store_run: cover property (is_store ##1 MEM_ST.wr);
    c_load_run:  cover property (is_load ##1 prod.valid);
    c_overflow:  cover property (prod.valid && state_q.cfg[ccm_pkg::CFG_SAT] && ccm_pkg::ovf33(sum_re));

endmodule

// *** pkg/ccm_pkg.sv ***
// Constants, carrier types and arithmetic helpers for the complex conjugate multiplier
// How it works
// - Operands are packed 16-bit real/imag halves
// - Results are 32-bit real and imaginary
// - Pack bit set means low half real
// - Pack clear: real high*high+low*low, imag cross-difference
// - Pack set: real low*low+high*high, swapped difference
// - Saturation enable clamps, otherwise results wrap
// - Real overflow sets the real flag
// - Imaginary overflow sets the imaginary flag
// - Plain multiply delivers results in two cycles
// - Parallel store finishes in one cycle
// - Store writes parallel register to memory
// - Parallel load fills register in one cycle
// - Decode plain multiply single opcode word
// - Decode parallel store low word, high fields
// - Decode parallel load with same layout
package ccm_pkg;

    // ************************************************************
    // Opcodes and instruction fields
    // ************************************************************
    localparam logic [15:0] OPC_PLAIN    = 16'hE50E;
    localparam logic [15:0] OPC_STORE    = 16'hE307;
    localparam logic [15:0] OPC_LOAD     = 16'hE3F6;
    localparam logic [3:0]  MSW_TAG      = 4'h1;
    localparam int          MSW_TAG_LSB  = 12;
    localparam int          MSW_SEL_LSB  = 8;
    localparam int          MSW_MEM_LSB  = 0;
    localparam int          MEM_AW       = 8;

    // ************************************************************
    // Vector register indices and bus map
    // ************************************************************
    localparam int          NUM_VREG     = 9;
    localparam int          IDX_X        = 0;
    localparam int          IDX_Y        = 1;
    localparam int          IDX_IMAG     = 2;
    localparam int          IDX_REAL     = 3;
    localparam int          IDX_EXTRA    = 8;
    localparam logic [5:0]  OFF_VREG     = 6'h00;
    localparam logic [5:0]  OFF_STATUS   = 6'h24;
    localparam logic [5:0]  OFF_CONFIG   = 6'h28;
    localparam int          ST_OVF_RE    = 0;
    localparam int          ST_OVF_IM    = 1;
    localparam int          CFG_PACK     = 0;
    localparam int          CFG_SAT      = 1;
    localparam logic [1:0]  CONFIG_RST   = 2'b00;
    localparam logic [31:0] VREG_RST     = 32'h0000_0000;
    localparam logic [31:0] SAT_POS      = 32'h7FFF_FFFF;
    localparam logic [31:0] SAT_NEG      = 32'h8000_0000;
    localparam int          MUL_LATENCY  = 2;

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic        valid;
        logic [15:0] lsw;
        logic [15:0] msw;
    } ccm_insn_t;

    typedef struct packed {
        logic              wr;
        logic [MEM_AW-1:0] addr;
        logic [31:0]       data;
    } ccm_store_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] re_a;
        logic [31:0] re_b;
        logic [31:0] im_a;
        logic [31:0] im_b;
    } ccm_prod_t;

    // ************************************************************
    // Arithmetic helpers
    // ************************************************************
    // Signed 16x16 product, never overflows 32 bits
    function automatic logic [31:0] mul16(input logic [15:0] a, input logic [15:0] b);
        mul16 = 32'($signed(a) * $signed(b));
    endfunction

    // Sign-extended sum or difference of two products
    function automatic logic [32:0] sum33(input logic [31:0] a, input logic [31:0] b, input logic sub);
        sum33 = sub ? ({a[31], a} - {b[31], b}) : ({a[31], a} + {b[31], b});
    endfunction

    // Out of 32-bit range when the two top bits disagree
    function automatic logic ovf33(input logic [32:0] s);
        ovf33 = s[32] ^ s[31];
    endfunction

    // Clamp on overflow when enabled, else keep the wrapped low word
    function automatic logic [31:0] fit32(input logic [32:0] s, input logic sat);
        if (sat && ovf33(s)) begin
            fit32 = s[32] ? SAT_NEG : SAT_POS;
        end else begin
            fit32 = s[31:0];
        end
    endfunction

endpackage

// *** verilog/ccm_mul_stage.sv ***
// First pipeline stage: half selection and the four signed products
`timescale 1ns/1ps
module ccm_mul_stage (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              start,
    input  wire logic              pack,
    input  wire logic [31:0]       op_x,
    input  wire logic [31:0]       op_y,
    output ccm_pkg::ccm_prod_t     prod
);

    ccm_pkg::ccm_prod_t state_q;
    ccm_pkg::ccm_prod_t state_d;
    logic [15:0]        xr;
    logic [15:0]        xi;
    logic [15:0]        yr;
    logic [15:0]        yi;

    // ************************************************************
    // Half selection and products
    // ************************************************************
    // Uniform real/imag form covers both packing orders
    always_comb begin
        xr = pack ? op_x[15:0] : op_x[31:16];
        xi = pack ? op_x[31:16] : op_x[15:0];
        yr = pack ? op_y[15:0] : op_y[31:16];
        yi = pack ? op_y[31:16] : op_y[15:0];
        state_d       = state_q;
        state_d.valid = start;
        // Products only load on issue to save toggling
        if (start) begin
            state_d.re_a = ccm_pkg::mul16(xr, yr);
            state_d.re_b = ccm_pkg::mul16(xi, yi);
            state_d.im_a = ccm_pkg::mul16(xr, yi);
            state_d.im_b = ccm_pkg::mul16(xi, yr);
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign prod = state_q;

endmodule

// *** sim/ccm_mem_model.sv ***
// Behavioural model of the data memory that sits behind the parallel move port
`timescale 1ns/1ps
module ccm_mem_model (
    input  wire logic           clk,
    input  ccm_pkg::ccm_insn_t  insn,
    input  ccm_pkg::ccm_store_t st,
    output logic [31:0]         rdata
);
    // ************************************************************
    // Storage
    // ************************************************************
    logic [31:0] mem [256];
    logic [31:0] last_q;

    // Known pattern per word so a load from the wrong address shows up
    initial begin
        last_q = 32'h0000_0000;
        for (int i = 0; i < 256; i++) begin
            mem[i] = {8'hC3, 8'(i), ~8'(i), 8'h5A};
        end
    end

    // Word presented in the issue cycle; bus shows the inverse of the last word otherwise
    assign rdata = insn.valid ? mem[insn.msw[7:0]] : ~last_q;

    // Stores land at the edge that ends the store pulse cycle
    always @(posedge clk) begin
        if (insn.valid) begin
            last_q <= mem[insn.msw[7:0]];
        end
        if (st.wr) begin
            mem[st.addr] <= st.data;
        end
    end
endmodule

// *** sim/tb_ccm_top.sv ***
// Self-checking testbench for the complex conjugate multiplier
`timescale 1ns/1ps
module tb_ccm_top;
    // ************************************************************
    // Signals and state
    // ************************************************************
    logic                clk = 1'b0;
    logic                sys_rst = 1'b1;
    logic [5:0]          avs_address = 6'h00;
    logic                avs_read = 1'b0;
    logic                avs_write = 1'b0;
    logic [31:0]         avs_writedata = 32'h0000_0000;
    logic [31:0]         avs_readdata;
    logic                avs_waitrequest;
    ccm_pkg::ccm_insn_t  insn = '0;
    logic [31:0]         mem_rdata;
    ccm_pkg::ccm_store_t mem_st;
    logic                real_ovf;
    logic                imag_ovf;
    int                  errors = 0;
    int                  comparisons = 0;
    int                  cycles = 0;
    logic                flag_re = 1'b0;
    logic                flag_im = 1'b0;
    logic [31:0]         last_re = 32'h0000_0000;
    logic [31:0]         st_val = 32'hA5A5_0F0F;
    // Operand table: x, y, config {sat, pack}, low and high opcode words
    logic [31:0] tx [7] = '{32'h0003_0002, 32'h0003_0002, 32'h8000_8000, 32'h8000_8000,
                            32'h8000_8000, 32'h1234_FEDC, 32'hFFFE_0004};
    logic [31:0] ty [7] = '{32'h0005_0007, 32'h0005_0007, 32'h8000_8000, 32'h8000_8000,
                            32'h8000_8000, 32'h0F0F_8001, 32'h7FFF_8000};
    logic [1:0]  tc [7] = '{2'h0, 2'h1, 2'h0, 2'h2, 2'h3, 2'h1, 2'h0};
    logic [15:0] tl [7] = '{16'hE50E, 16'hE307, 16'hE3F6, 16'hE50E, 16'hE307, 16'hE3F6, 16'hE50E};
    logic [15:0] tm [7] = '{16'h0000, 16'h1530, 16'h1631, 16'h0000, 16'h1530, 16'h1631, 16'h0000};

    // ************************************************************
    // Clock, instances, timeout
    // ************************************************************
    always #12.5 clk = ~clk;

    ccm_top ccm_top_inst (.CLK(clk), .SYS_RST(sys_rst), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
        .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
        .AVS_WAITREQUEST(avs_waitrequest), .INSN(insn), .MEM_RDATA(mem_rdata), .MEM_ST(mem_st),
        .REAL_OVF(real_ovf), .IMAG_OVF(imag_ovf));

    ccm_mem_model ccm_mem_model_inst (.clk(clk), .insn(insn), .st(mem_st), .rdata(mem_rdata));

    // Whole run is well under this; a stuck handshake ends here
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            errors++;
            close_out();
        end
    end

    // ************************************************************
    // Tasks and helpers
    // ************************************************************
    task automatic close_out();
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk32(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic chk1(input string name, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %b seen %b", name, exp, got);
        end
    endtask

    // Request held until the rising edge that sees waitrequest low; data taken and request dropped there
    task automatic av_xfer(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        avs_address   <= a;
        avs_write     <= wr;
        avs_read      <= ~wr;
        avs_writedata <= d;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk);
        end
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr32(input logic [5:0] a, input logic [31:0] d);
        logic [31:0] q;
        av_xfer(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string name, input logic [5:0] a, input logic [31:0] exp);
        logic [31:0] q;
        av_xfer(1'b0, a, 32'h0000_0000, q);
        chk32(name, exp, q);
    endtask

    // Holds the instruction for one cycle; the next issue or idle ends it
    task automatic issue(input logic [15:0] lsw, input logic [15:0] msw);
        @(posedge clk);
        insn <= '{valid: 1'b1, lsw: lsw, msw: msw};
    endtask

    task automatic idle();
        @(posedge clk);
        insn.valid <= 1'b0;
    endtask

    function automatic logic [31:0] memval(input logic [7:0] a);
        return {8'hC3, a, ~a, 8'h5A};
    endfunction

    function automatic longint prod(input logic [15:0] a, input logic [15:0] b);
        return longint'($signed(a)) * longint'($signed(b));
    endfunction

    function automatic logic ovf(input longint v);
        return (v > 64'sh0000_0000_7FFF_FFFF) || (v < -64'sh0000_0000_8000_0000);
    endfunction

    function automatic logic [31:0] fit(input longint v, input logic sat);
        if (sat && ovf(v)) begin
            return (v < 0) ? 32'h8000_0000 : 32'h7FFF_FFFF;
        end
        return v[31:0];
    endfunction

    // One multiply of any form, with flag timing, store pulse and results checked
    task automatic mul_case(input logic [31:0] x, input logic [31:0] y, input logic [1:0] cfg,
                            input logic [15:0] lsw, input logic [15:0] msw);
        logic [15:0] rx, ix, ry, iy;
        longint      re, im;
        logic        f_old;
        rx = cfg[0] ? x[15:0] : x[31:16];
        ix = cfg[0] ? x[31:16] : x[15:0];
        ry = cfg[0] ? y[15:0] : y[31:16];
        iy = cfg[0] ? y[31:16] : y[15:0];
        re = prod(rx, ry) + prod(ix, iy);
        im = prod(rx, iy) - prod(ix, ry);
        wr32(6'h00, x);
        wr32(6'h04, y);
        wr32(6'h28, {30'h0000_0000, cfg});
        f_old = flag_re;
        flag_re = flag_re | ovf(re);
        flag_im = flag_im | ovf(im);
        last_re = fit(re, cfg[1]);
        issue(lsw, msw);
        idle();
        @(negedge clk);
        chk1("real_ovf_early", f_old, real_ovf);
        chk1("store_wr", lsw == 16'hE307, mem_st.wr);
        if (lsw == 16'hE307) begin
            chk32("store_data", st_val, mem_st.data);
            chk32("store_addr", {24'h00_0000, msw[7:0]}, {24'h00_0000, mem_st.addr});
        end
        @(negedge clk);
        chk1("real_ovf", flag_re, real_ovf);
        chk1("imag_ovf", flag_im, imag_ovf);
        rd_chk("real_res", 6'h0C, fit(re, cfg[1]));
        rd_chk("imag_res", 6'h08, fit(im, cfg[1]));
        if (lsw == 16'hE3F6) begin
            rd_chk("load_reg", {msw[11:8], 2'b00}, memval(msw[7:0]));
        end
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (8) @(posedge clk);
        sys_rst <= 1'b0;
        // Reset state of every mapped word, and an unmapped hole that ignores writes
        for (int i = 0; i < 9; i++) begin
            rd_chk("vreg_reset", 6'(4 * i), 32'h0000_0000);
        end
        rd_chk("status_reset", 6'h24, 32'h0000_0000);
        rd_chk("config_reset", 6'h28, 32'h0000_0000);
        wr32(6'h2C, 32'hFFFF_FFFF);
        rd_chk("unmapped", 6'h2C, 32'h0000_0000);
        chk1("real_ovf_reset", 1'b0, real_ovf);
        wr32(6'h14, st_val);
        // Every form and pack/saturate mode; flags cleared in mid-table
        for (int i = 0; i < 7; i++) begin
            mul_case(tx[i], ty[i], tc[i], tl[i], tm[i]);
            if (i == 3) begin
                rd_chk("status", 6'h24, {30'h0000_0000, flag_im, flag_re});
                wr32(6'h24, 32'h0000_0003);
                flag_re = 1'b0;
                flag_im = 1'b0;
                rd_chk("status_clear", 6'h24, 32'h0000_0000);
            end
        end
        // A near-miss opcode and a store with a wrong high-word tag change nothing
        wr32(6'h00, 32'h0001_0001);
        issue(16'hE50F, 16'h0000);
        issue(16'hE307, 16'h2530);
        idle();
        @(negedge clk);
        chk1("bad_tag_wr", 1'b0, mem_st.wr);
        rd_chk("real_kept", 6'h0C, last_re);
        // Loaded word is already visible to the very next instruction
        issue(16'hE3F6, 16'h1440);
        issue(16'hE307, 16'h1441);
        idle();
        @(negedge clk);
        chk32("fwd_store", memval(8'h40), mem_st.data);
        @(negedge clk);
        chk32("mem_written", memval(8'h40), ccm_mem_model_inst.mem[8'h41]);
        close_out();
    end
endmodule
